// [verification/cbm_agu_model.sv]
// Pointer register model standing in for the core address unit
`timescale 1ns/1ps
module cbm_agu_model (
   input  wire logic        sys_clk,
   input  wire logic        load_en,
   input  wire logic        step_en,
   input  wire logic [15:0] load_val,
   input  wire logic [15:0] step_val,
   input  wire logic [15:0] eff,
   output logic      [15:0] cur,
   output logic      [15:0] nxt
);
   // Pointer takes back the wrapped address, as the core does
   always_ff @(posedge sys_clk) begin
      if (load_en) cur <= load_val;
      else if (step_en) cur <= eff;
   end
   // Plain update before any wrap
   assign nxt = cur + step_val;
endmodule : cbm_agu_model

// [verification/cbm_top_properties.sv]
// Concurrent checks on the circular buffer unit ports
`timescale 1ns/1ps
module cbm_top_properties
   import cbm_pkg::*;
#(parameter int W = 16) (
   input wire logic                  sys_clk, nrst, s_axi_awvalid, s_axi_awready,
   input wire logic                  s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
   input wire logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic [CBM_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [31:0]           s_axi_wdata, s_axi_rdata,
   input wire logic [3:0]            xr_reg,
   input wire logic [W-1:0]          xr_cur, xr_nxt, xr_eff, xw_nxt, xw_eff, y_nxt, y_eff
);
   logic [15:0] ctl_ff, xs_ff, xe_ff;
   logic        pend_ff, q, xen, xon, yen, tk;
   // Shadow of the written control and X bound registers, quiet once the response is gone
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         {ctl_ff, xs_ff, xe_ff, pend_ff} <= {CBM_CTRL_RST, 33'h000000000};
      end else begin
         pend_ff <= tk || (pend_ff && !(s_axi_bvalid && s_axi_bready));
         if (tk && s_axi_awaddr == CBM_OFS_CTRL) ctl_ff <= s_axi_wdata[15:0];
         if (tk && s_axi_awaddr == CBM_OFS_XSTART) xs_ff <= s_axi_wdata[15:0];
         if (tk && s_axi_awaddr == CBM_OFS_XEND) xe_ff <= s_axi_wdata[15:0];
      end
   end
   assign tk = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign q = !pend_ff && !s_axi_bvalid;
   assign xen = ctl_ff[15] && ctl_ff[3:0] != CBM_SEL_NONE;
   assign xon = xen && xr_reg == ctl_ff[3:0];
   assign yen = ctl_ff[14] && ctl_ff[7:4] != CBM_SEL_NONE;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   x_lane_off_a: assert property (q && !xen |-> xr_eff == xr_nxt && xw_eff == xw_nxt)
      else $error("x lane altered while off");
   x_sel_other_a: assert property (q && xen && !xon |-> xr_eff == xr_nxt)
      else $error("x lane altered for other pointer");
   y_lane_off_a: assert property (q && !yen |-> y_eff == {y_nxt[W-1:1], 1'b0})
      else $error("y lane altered while off");
   y_word_a: assert property (y_eff[0] == 1'b0)
      else $error("y address odd");
   x_wrap_up_a: assert property (q && xon && xr_nxt > xr_cur && xr_nxt > xe_ff
      |-> xr_eff == W'(xs_ff + xr_nxt - xe_ff - 1)) else $error("x upward wrap wrong");
   x_wrap_down_a: assert property (q && xon && xr_nxt < xr_cur && xr_nxt < xs_ff
      |-> xr_eff == W'(xe_ff - xs_ff + xr_nxt + 1)) else $error("x downward wrap wrong");
   x_inside_a: assert property (q && xon && xr_nxt >= xs_ff && xr_nxt <= xe_ff
      |-> xr_eff == xr_nxt) else $error("x address moved inside buffer");
   write_resp_a: assert property (tk |-> ##2 s_axi_bvalid)
      else $error("write response late");
   read_resp_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && s_axi_rdata[31:19] == 13'h0000) else $error("read answer wrong");
endmodule : cbm_top_properties
bind cbm_top cbm_top_properties #(.W(W)) cbm_top_properties_inst (.sys_clk(sys_clk),
   .nrst(nrst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata),
   .s_axi_rdata(s_axi_rdata), .xr_reg(xr_reg), .xr_cur(xr_cur), .xr_nxt(xr_nxt),
   .xr_eff(xr_eff), .xw_nxt(xw_nxt), .xw_eff(xw_eff), .y_nxt(y_nxt), .y_eff(y_eff));

// [verification/cbm_top_test.sv]
// Self-checking bench for the circular buffer unit
`timescale 1ns/1ps
module cbm_top_test;
   import cbm_pkg::*;
   logic        sys_clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        ld = 1'b1, go = 1'b0;
   logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0]  rx = 4'h0, ry = 4'h0;
   logic [15:0] step = 16'h0002;
   logic [47:0] ld_val = {16'h2010, 16'h1010, 16'h1010};
   logic [15:0] bnd [4] = '{16'h1000, 16'h101F, 16'h2000, 16'h201E};
   wire  [47:0] cur_w, nxt_w, eff_w;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   logic [33:0] bus_q [$];
   logic [47:0] ln_q [$];
   int          err_total = 0, cmp_count = 0;
   always #5 sys_clk = ~sys_clk;
   cbm_top cbm_top_inst (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .xr_reg(rx),
      .xr_cur(cur_w[15:0]), .xr_nxt(nxt_w[15:0]), .xr_eff(eff_w[15:0]), .xw_reg(rx),
      .xw_cur(cur_w[31:16]), .xw_nxt(nxt_w[31:16]), .xw_eff(eff_w[31:16]), .y_reg(ry),
      .y_cur(cur_w[47:32]), .y_nxt(nxt_w[47:32]), .y_eff(eff_w[47:32]));
   cbm_agu_model cbm_agu_model_inst [2:0] (.sys_clk(sys_clk), .load_en(ld), .step_en(go),
      .load_val(ld_val), .step_val(step), .eff(eff_w), .cur(cur_w), .nxt(nxt_w));
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // One bus transfer, expectation noted before it starts
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      bus_q.push_back({r, w ? 32'h00000000 : d});
      if (w) begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
      end else begin
         araddr <= a;
         arvalid <= 1'b1;
      end
      do begin
         @(posedge sys_clk);
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
         if (arready && arvalid) arvalid <= 1'b0;
         n++;
         if (n > 50) begin
            err_total++;
            report_and_stop();
         end
      end while (!(w ? bvalid : rvalid));
   endtask : xfer
   // Expected lane address after one pointer update
   function automatic logic [15:0] ew(input logic on, input logic y, input logic [15:0] c,
                                      input logic [15:0] n, s, e);
      logic [15:0] r;
      r = n;
      if (on && n > c && n > e) r = s + n - e - (y ? 16'h0002 : 16'h0001);
      else if (on && n < c && n < s) r = e - (s - n) + (y ? 16'h0002 : 16'h0001);
      if (y) r[0] = 1'b0;
      return r;
   endfunction : ew
   // Walk all lanes up, down and at random under one control word
   task automatic walk(input logic [15:0] c);
      logic xon, yon;
      xon = c[15] && c[3:0] != CBM_SEL_NONE && c[3:0] == rx;
      yon = c[14] && c[7:4] != CBM_SEL_NONE && c[7:4] == ry;
      xfer(1'b1, CBM_OFS_CTRL, {16'h0007, c}, CBM_RESP_OKAY);
      xfer(1'b0, CBM_OFS_CTRL, {16'h0000, c}, CBM_RESP_OKAY);
      ld <= 1'b1;
      for (int i = 0; i < 60; i++) begin
         @(posedge sys_clk);
         ld <= 1'b0;
         go <= 1'b1;
         step <= (i < 20 || (i >= 40 && $urandom_range(1))) ? 16'h0002 : 16'hFFFE;
         @(negedge sys_clk);
         ln_q.push_back({ew(yon, 1'b1, cur_w[47:32], nxt_w[47:32], bnd[2], bnd[3]),
            ew(xon, 1'b0, cur_w[31:16], nxt_w[31:16], bnd[0], bnd[1]),
            ew(xon, 1'b0, cur_w[15:0], nxt_w[15:0], bnd[0], bnd[1])});
      end
      @(posedge sys_clk);
      go <= 1'b0;
      ld <= 1'b1; // Park pointers inside so the next control write sees no wrap
      xfer(1'b0, CBM_OFS_CTRL, {13'h0000, yon, xon, xon, c}, CBM_RESP_OKAY);
   endtask : walk
   // Results compared against the oldest note
   always @(posedge sys_clk) begin
      if (nrst && bvalid) chk("write response", {bresp, 32'h00000000}, bus_q.pop_front());
      if (nrst && rvalid) chk("read data", {rresp, rdata}, bus_q.pop_front());
      if (go) chk("lane addresses", eff_w, ln_q.pop_front());
   end
   initial begin
      void'($urandom(32'h554C2819));
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 5; i++)
         xfer(1'b0, 5'(4 * i), {16'h0000, i ? CBM_BND_RST : CBM_CTRL_RST}, CBM_RESP_OKAY);
      for (int i = 0; i < 8; i++)
         xfer(i < 4, 5'(4 * (i % 4) + 4), {16'h0000, bnd[i % 4]}, CBM_RESP_OKAY);
      xfer(1'b1, 5'h14, 32'h0000FFFF, CBM_RESP_SLVERR);
      xfer(1'b0, 5'h1C, 32'h00000000, CBM_RESP_SLVERR);
      rx <= 4'($urandom_range(13));
      ry <= 4'($urandom_range(13));
      @(posedge sys_clk);
      walk({8'hC0, ry, rx});
      walk({8'hC0, 8'hFF});
      walk({8'h00, ry, rx});
      walk({8'hC0, ry ^ 4'h1, rx ^ 4'h1});
      report_and_stop();
   end
endmodule : cbm_top_test

// [verilog/cbm_agen.sv]
// One modulo address generator lane: wraps a pointer update into its buffer
`timescale 1ns/1ps
module cbm_agen
   import cbm_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic [W-1:0] cur_addr,
   input  wire logic [W-1:0] nxt_addr,
   input  wire logic [3:0]   ptr_sel,
   input  wire logic         active,
   input  wire logic         word_mode,
   input  wire logic [W-1:0] buf_start,
   input  wire logic [W-1:0] buf_end,
   output logic      [W-1:0] eff_addr,
   output logic              wrapped
);
   logic [W-1:0] lo;
   logic [W-1:0] hi;
   logic [W-1:0] step;
   logic         up;
   logic         down;
   logic         hit;

   // Word lanes ignore the byte bit; the span between the bounds is the length
   assign lo   = word_mode ? {buf_start[W-1:1], 1'b0} : buf_start;
   assign hi   = word_mode ? {buf_end[W-1:1], 1'b0} : buf_end;
   // Direction follows each update; odd lengths must keep to one direction
   assign up   = nxt_addr > cur_addr;
   assign down = nxt_addr < cur_addr;
   // A pointer numbered like the off select is never circular
   assign hit  = active && (ptr_sel != CBM_SEL_NONE);
   assign step = up ? W'(nxt_addr - cur_addr) : W'(cur_addr - nxt_addr);

   // Both boundaries checked each update, so power-of-two buffers run either way
   always_comb begin
      eff_addr = nxt_addr;
      wrapped  = 1'b0;
      if (hit && up && nxt_addr > hi) begin
         eff_addr = W'(lo + (nxt_addr - hi) - (word_mode ? W'(2) : W'(1)));
         wrapped  = 1'b1;
      end else if (hit && down && nxt_addr < lo) begin
         eff_addr = W'(hi - (lo - nxt_addr) + (word_mode ? W'(2) : W'(1)));
         wrapped  = 1'b1;
      end
      if (word_mode) begin
         eff_addr[0] = 1'b0;
      end
      if (step == '0) begin
         wrapped = 1'b0;
      end
   end
endmodule : cbm_agen

// [verilog/cbm_pkg.sv]
// Package with register map, field layout and reset values of the circular buffer unit
package cbm_pkg;
   // Register byte offsets on the bus
   localparam logic [4:0] CBM_OFS_CTRL    = 5'h00;
   localparam logic [4:0] CBM_OFS_XSTART  = 5'h04;
   localparam logic [4:0] CBM_OFS_XEND    = 5'h08;
   localparam logic [4:0] CBM_OFS_YSTART  = 5'h0C;
   localparam logic [4:0] CBM_OFS_YEND    = 5'h10;
   localparam int         CBM_ADDR_W      = 5;
   // Control field positions
   localparam int         CBM_XSEL_LSB    = 0;
   localparam int         CBM_YSEL_LSB    = 4;
   localparam int         CBM_YEN_BIT     = 14;
   localparam int         CBM_XEN_BIT     = 15;
   localparam logic [3:0] CBM_SEL_NONE    = 4'hF;
   // Reset values
   localparam logic [15:0] CBM_CTRL_RST   = 16'h00FF;
   localparam logic [15:0] CBM_BND_RST    = 16'h0000;
   // Bus responses
   localparam logic [1:0] CBM_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CBM_RESP_SLVERR = 2'h2;
   // Register index numbers inside the register bank
   localparam logic [2:0] CBM_IDX_CTRL    = 3'h0;
   localparam logic [2:0] CBM_IDX_XSTART  = 3'h1;
   localparam logic [2:0] CBM_IDX_XEND    = 3'h2;
   localparam logic [2:0] CBM_IDX_YSTART  = 3'h3;
   localparam logic [2:0] CBM_IDX_YEND    = 3'h4;
endpackage : cbm_pkg

// [verilog/cbm_top.sv]
// Circular buffer modulo unit: AXI4-Lite registers and X/Y wrap lanes
`timescale 1ns/1ps
module cbm_top
   import cbm_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic                  sys_clk,
   input  wire logic                  nrst,
   // Register bus
   input  wire logic [CBM_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [CBM_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Core address lanes: pointer number, pointer before and after the update
   input  wire logic [3:0]            xr_reg,
   input  wire logic [W-1:0]          xr_cur,
   input  wire logic [W-1:0]          xr_nxt,
   output logic [W-1:0]               xr_eff,
   input  wire logic [3:0]            xw_reg,
   input  wire logic [W-1:0]          xw_cur,
   input  wire logic [W-1:0]          xw_nxt,
   output logic [W-1:0]               xw_eff,
   input  wire logic [3:0]            y_reg,
   input  wire logic [W-1:0]          y_cur,
   input  wire logic [W-1:0]          y_nxt,
   output logic [W-1:0]               y_eff
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   // Every register of the block lives in this one struct
   typedef struct packed {
      logic [15:0]           ctrl;
      logic [15:0]           xstart;
      logic [15:0]           xend;
      logic [15:0]           ystart;
      logic [15:0]           yend;
      logic                  aw_got;
      logic [CBM_ADDR_W-1:0] aw_addr;
      logic                  w_got;
      logic [31:0]           w_data;
      logic [3:0]            w_strb;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [1:0]            rresp;
      logic [31:0]           rdata;
      logic [2:0]            wraps;
   } cbm_state_t;

   cbm_state_t st_ff;
   cbm_state_t nxt_st;

   logic         x_active;
   logic         y_active;
   logic [W-1:0] xr_w;
   logic [W-1:0] xw_w;
   logic [W-1:0] y_w;
   logic         xr_wrap;
   logic         xw_wrap;
   logic         y_wrap;
   logic         xr_on;
   logic         xw_on;
   logic         y_on;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Map a byte offset to a register index, 3'h7 when unmapped
   // Every offset outside the map folds into the error answer
   function automatic logic [2:0] cbm_decode(input logic [CBM_ADDR_W-1:0] a);
      case (a)
         CBM_OFS_CTRL:   cbm_decode = CBM_IDX_CTRL;
         CBM_OFS_XSTART: cbm_decode = CBM_IDX_XSTART;
         CBM_OFS_XEND:   cbm_decode = CBM_IDX_XEND;
         CBM_OFS_YSTART: cbm_decode = CBM_IDX_YSTART;
         CBM_OFS_YEND:   cbm_decode = CBM_IDX_YEND;
         default:        cbm_decode = 3'h7;
      endcase
   endfunction : cbm_decode

   // Merge the two low byte lanes of a write into a 16-bit register
   // Upper lanes never reach a bound or control bit
   function automatic logic [15:0] cbm_merge(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  s);
      cbm_merge = old;
      if (s[0]) begin
         cbm_merge[7:0] = d[7:0];
      end
      if (s[1]) begin
         cbm_merge[15:8] = d[15:8];
      end
   endfunction : cbm_merge

   // A lane is live when its space is on and the access uses the selected pointer
   function automatic logic cbm_lane_on(input logic       space_on,
                                        input logic [3:0] sel,
                                        input logic [3:0] ptr);
      cbm_lane_on = space_on && (ptr == sel);
   endfunction : cbm_lane_on

   ////////////////////////////////////////////////////////////////////////////
   // Lane usage limits, kept by software:
   //  - one circular buffer per space; both X lanes share the X bounds
   //  - the frame and stack pointers may be selected, but the core moves them
   //    on calls and returns, so wrapping them would corrupt the stack
   //  - a buffer whose length is not a power of two must only be walked in
   //    the direction its start or end alignment was chosen for
   //  - no length is stored; start and end alone bound the buffer, so one
   //    16-bit pair spans at most 32K words
   // Both bounds are checked on every update, so power-of-two buffers run
   // either way without extra set-up.
   //
   // Lane enables: select not 15 and the enable flag set
   assign x_active = (st_ff.ctrl[CBM_XSEL_LSB +: 4] != CBM_SEL_NONE)
                     && st_ff.ctrl[CBM_XEN_BIT];
   assign y_active = (st_ff.ctrl[CBM_YSEL_LSB +: 4] != CBM_SEL_NONE)
                     && st_ff.ctrl[CBM_YEN_BIT];

   // Per-lane match of the access pointer against the space select
   assign xr_on = cbm_lane_on(x_active, st_ff.ctrl[CBM_XSEL_LSB +: 4], xr_reg);
   assign xw_on = cbm_lane_on(x_active, st_ff.ctrl[CBM_XSEL_LSB +: 4], xw_reg);
   assign y_on  = cbm_lane_on(y_active, st_ff.ctrl[CBM_YSEL_LSB +: 4], y_reg);

   // X read lane, also used for program space pointers
   cbm_agen #(.W(W)) u_xr (
      .cur_addr  (xr_cur),
      .nxt_addr  (xr_nxt),
      .ptr_sel   (xr_reg),
      .active    (xr_on),
      .word_mode (1'b0),
      .buf_start (st_ff.xstart),
      .buf_end   (st_ff.xend),
      .eff_addr  (xr_w),
      .wrapped   (xr_wrap)
   );

   // X write lane shares the X buffer
   // Same select as the read lane: one X buffer serves both
   cbm_agen #(.W(W)) u_xw (
      .cur_addr  (xw_cur),
      .nxt_addr  (xw_nxt),
      .ptr_sel   (xw_reg),
      .active    (xw_on),
      .word_mode (1'b0),
      .buf_start (st_ff.xstart),
      .buf_end   (st_ff.xend),
      .eff_addr  (xw_w),
      .wrapped   (xw_wrap)
   );

   // Y lane, word addressed, independent buffer
   // Bit 0 of every Y address is forced low
   cbm_agen #(.W(W)) u_y (
      .cur_addr  (y_cur),
      .nxt_addr  (y_nxt),
      .ptr_sel   (y_reg),
      .active    (y_on),
      .word_mode (1'b1),
      .buf_start (st_ff.ystart),
      .buf_end   (st_ff.yend),
      .eff_addr  (y_w),
      .wrapped   (y_wrap)
   );

   // Effective addresses are combinational on the core address path
   // Registering them would cost the core a cycle on every access
   assign xr_eff = xr_w;
   assign xw_eff = xw_w;
   assign y_eff  = y_w;

   // Handshake outputs
   // Each write half is refused once held, and both while a response waits,
   // so a second write can never overwrite a held address or data word
   assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
   assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rresp   = st_ff.rresp;
   assign s_axi_rdata   = st_ff.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Next state: bus slave and register bank
   // Write address and data may come in either order or together;
   // the response follows one cycle after both halves are held
   always_comb begin
      logic [2:0] widx;
      logic [2:0] ridx;
      nxt_st = st_ff;
      widx   = 3'h0;
      ridx   = 3'h0;
      // Sticky record of wraps, readable in control upper half
      // A wrap in the same cycle as its clear keeps the flag set
      nxt_st.wraps = st_ff.wraps | {y_wrap, xw_wrap, xr_wrap};
      // Capture write address and data in any order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_got  = 1'b1;
         nxt_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_got  = 1'b1;
         nxt_st.w_data = s_axi_wdata;
         nxt_st.w_strb = s_axi_wstrb;
      end
      // Commit once both halves are held
      // Only byte lanes 0 and 1 reach a register; lane 2 of a control write clears wrap flags
      if (st_ff.aw_got && st_ff.w_got) begin
         widx          = cbm_decode(st_ff.aw_addr);
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = CBM_RESP_OKAY;
         case (widx)
            CBM_IDX_CTRL:   nxt_st.ctrl   = cbm_merge(st_ff.ctrl, st_ff.w_data, st_ff.w_strb);
            CBM_IDX_XSTART: nxt_st.xstart = cbm_merge(st_ff.xstart, st_ff.w_data,
                                                      st_ff.w_strb);
            CBM_IDX_XEND:   nxt_st.xend   = cbm_merge(st_ff.xend, st_ff.w_data,
                                                      st_ff.w_strb);
            CBM_IDX_YSTART: nxt_st.ystart = cbm_merge(st_ff.ystart, st_ff.w_data,
                                                      st_ff.w_strb);
            CBM_IDX_YEND:   nxt_st.yend   = cbm_merge(st_ff.yend, st_ff.w_data,
                                                      st_ff.w_strb);
            default:        nxt_st.bresp  = CBM_RESP_SLVERR;
         endcase
         // Writing 1 to bit 16+n of control clears wrap flag n, set wins
         if (widx == CBM_IDX_CTRL && st_ff.w_strb[2]) begin
            nxt_st.wraps = (st_ff.wraps & ~st_ff.w_data[18:16])
                           | {y_wrap, xw_wrap, xr_wrap};
         end
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      // Read path: data registered one cycle after the address
      // Unmapped offsets answer with an error and zero data
      if (s_axi_arvalid && s_axi_arready) begin
         ridx          = cbm_decode(s_axi_araddr);
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = CBM_RESP_OKAY;
         case (ridx)
            CBM_IDX_CTRL:   nxt_st.rdata = {13'h0000, st_ff.wraps, st_ff.ctrl};
            CBM_IDX_XSTART: nxt_st.rdata = {16'h0000, st_ff.xstart};
            CBM_IDX_XEND:   nxt_st.rdata = {16'h0000, st_ff.xend};
            CBM_IDX_YSTART: nxt_st.rdata = {16'h0000, st_ff.ystart};
            CBM_IDX_YEND:   nxt_st.rdata = {16'h0000, st_ff.yend};
            default: begin
               nxt_st.rdata = 32'h0000_0000;
               nxt_st.rresp = CBM_RESP_SLVERR;
            end
         endcase
      end else if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   // Register the whole state
   // Bounds clear and both selects read 15, so every lane starts off
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff        <= '0;
         st_ff.ctrl   <= CBM_CTRL_RST;
         st_ff.xstart <= CBM_BND_RST;
         st_ff.xend   <= CBM_BND_RST;
         st_ff.ystart <= CBM_BND_RST;
         st_ff.yend   <= CBM_BND_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : cbm_top
